/* shared/prs_map.vh */
`ifndef PRS_MAP_VH
`define PRS_MAP_VH

// Register byte offsets on the AXI4-Lite slave.
`define PRS_OFS_CTRL      8'h00
`define PRS_OFS_PENDING   8'h04
`define PRS_OFS_COMPARE   8'h08
`define PRS_OFS_COUNT     8'h0C
`define PRS_OFS_STATUS    8'h10
`define PRS_OFS_CLKCFG    8'h14
`define PRS_OFS_SCRATCH   8'h18

// Field positions in the first control register.
`define PRS_CTRL_SOFT_RESET_BIT    0
`define PRS_CTRL_ENABLE   1
`define PRS_CTRL_KEEPRUN  6

// Field positions in the clock configuration register.
`define PRS_CFG_GEN_EN    0
`define PRS_CFG_CHAN_EN   1
`define PRS_CFG_ONREQ     2
`define PRS_CFG_RESET     32'h00000004

// Synchroniser channel numbers, also the bit positions of the pending register.
`define PRS_SYNC_SOFT_RESET_BIT    0
`define PRS_SYNC_ENABLE   1
`define PRS_SYNC_COMPARE  2
`define PRS_SYNC_COUNT    3
`define PRS_SYNC_NUM      4

// Status register bits.
`define PRS_ST_READY      0
`define PRS_ST_REQ        1
`define PRS_ST_RUNNING    2
`define PRS_ST_AVAIL      3

// Handshake timing: generic clock pulses to reach the core, then bus cycles back.
`define PRS_SYNC_GENERIC_CLOCK_UNIT     3'd6
`define PRS_SYNC_RET      2'd1

// Bus clock and source startup time.
`define PRS_CLK_MHZ       250
`define PRS_STARTUP_NS    100
`define PRS_GENERIC_CLOCK_UNIT_DIV      4

`define PRS_RESP_OKAY     2'b00
`define PRS_RESP_SLVERR   2'b10
`define PRS_ZERO32        32'h00000000

`endif

/* design/prs_sync_bridge.v */
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "prs_map.vh"

//////////////////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - A changed core count is carried to the bus copy without a pending bit.
// - Reading the count returns the last carried value and launches nothing.
// - Wake-up sets the count pending bit; reads return the pre-sleep value meanwhile.
// - Sync-ready status is high whenever every pending bit is zero.
// - Writing the enable bit starts its sync and sets its pending bit until done.
// - The enable bit reads back its written value at once.
// - Writing one to soft reset starts its sync, sets pending, reads one at once.
// - When the reset completes, soft reset and its pending bit clear together.
// - Writing zero to soft reset does nothing.
// - Sync delay lies between 5 core plus 2 bus and 6 core plus 3 bus periods.
// - Bus-side registers answer writes in two bus periods and reads in one, without synchronisation.
// - With the bus interface clock masked, reads give zero and writes are dropped.
// - An on-request source runs only while some request is active.
// - A request reaches the source only when peripheral, channel and generator are enabled.
// - Start delay is startup time plus one-two source plus one-two divided periods.
// - Stop delay is one-two divided periods plus one-two source periods.
// - With on-request cleared the source runs continuously.
// - In standby a request stays only if keep-running is set.
// - A write to a register still synchronising is dropped and answered with an error.
// - Each synchronised register has its own synchroniser and pending bit.
// - A register synchronised both ways shares one pending bit.
// - The handshake always runs, even with equal clocks.
module prs_sync_bridge #(
  parameter GENERIC_CLOCK_UNIT_DIV    = `PRS_GENERIC_CLOCK_UNIT_DIV,
  parameter STARTUP_NS  = `PRS_STARTUP_NS,
  parameter COUNT_W     = 16
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire        bus_clk_unmasked,
  input  wire        standby,
  input  wire        wake_pulse,
  output wire        clock_request,
  output wire        source_running,
  output wire        clock_available
);

  localparam STARTUP_CYC = (STARTUP_NS * `PRS_CLK_MHZ + 999) / 1000;
  localparam SRC_OFF     = 3'd0;
  localparam SRC_START   = 3'd1;
  localparam SRC_ALIGN   = 3'd2;
  localparam SRC_RUN     = 3'd3;
  localparam SRC_HALT    = 3'd4;
  localparam SRC_LAST    = 3'd5;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        merge[k*8 +: 8] = strb[k] ? data[k*8 +: 8] : old[k*8 +: 8];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////////////
  // Generic clock enable divider; the core domain advances only on generic_clock_unit_en.

  reg  [7:0]  gdiv;
  wire        generic_clock_unit_en = (gdiv == 8'h00);

  always @(posedge aclk)
  begin
    if (!aresetn)
      gdiv <= 8'h00;
    else if (gdiv == GENERIC_CLOCK_UNIT_DIV[7:0] - 8'h01)
      gdiv <= 8'h00;
    else
      gdiv <= gdiv + 8'h01;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////
  // Bus-domain registers and AXI4-Lite slave.

  reg                ctl_soft_reset_bit;
  reg                ctl_enable;
  reg                ctl_keeprun;
  reg  [15:0]        compare_bus;
  reg  [COUNT_W-1:0] count_bus;
  reg  [31:0]        clkcfg;
  reg  [31:0]        scratch;
  reg                pend_count;
  reg                wake_launched;
  reg                count_dirty;
  reg                aw_full;
  reg                w_full;
  reg  [7:0]         aw_addr;
  reg  [31:0]        w_data;
  reg  [3:0]         w_strb;

  reg  [`PRS_SYNC_NUM-1:0] busy;
  reg  [2:0]               scnt [0:`PRS_SYNC_NUM-1];
  reg  [1:0]               sret [0:`PRS_SYNC_NUM-1];
  reg  [`PRS_SYNC_NUM-1:0] start;
  reg  [`PRS_SYNC_NUM-1:0] apply;
  reg  [`PRS_SYNC_NUM-1:0] done;

  wire [31:0] ctrl_word = {25'h0000000, ctl_keeprun, 4'h0, ctl_enable, ctl_soft_reset_bit};
  wire [31:0] pending   = {28'h0000000, pend_count, busy[`PRS_SYNC_COMPARE:0]};
  wire        sync_ready = (pending == `PRS_ZERO32);
  wire        wr_go     = aw_full && w_full && !bvalid;
  wire [31:0] wr_ctrl   = merge(ctrl_word, w_data, w_strb);
  wire [31:0] wr_cmp    = merge({16'h0000, compare_bus}, w_data, w_strb);
  wire        ctrl_busy = busy[`PRS_SYNC_SOFT_RESET_BIT] || busy[`PRS_SYNC_ENABLE];
  wire        rd_go     = arvalid && !rvalid;

  assign awready = !aw_full;
  assign wready  = !w_full;
  assign arready = !rvalid;

  reg [31:0] rd_word;
  reg        rd_bad;
  always @*
  begin
    rd_bad = 1'b0;
    case (araddr)
      `PRS_OFS_CTRL:    rd_word = ctrl_word;
      `PRS_OFS_PENDING: rd_word = pending;
      `PRS_OFS_COMPARE: rd_word = {16'h0000, compare_bus};
      `PRS_OFS_COUNT:   rd_word = {{(32-COUNT_W){1'b0}}, count_bus};
      `PRS_OFS_STATUS:  rd_word = {28'h0000000, clock_available, source_running, clock_request, sync_ready};
      `PRS_OFS_CLKCFG:  rd_word = clkcfg;
      `PRS_OFS_SCRATCH: rd_word = scratch;
      default:
      begin
        rd_word = `PRS_ZERO32;
        rd_bad  = 1'b1;
      end
    endcase
  end

  // Write decode: raises sync starts and decides the response.
  reg       wr_err;
  reg       wr_bad;
  always @*
  begin
    start  = {`PRS_SYNC_NUM{1'b0}};
    wr_err = 1'b0;
    wr_bad = 1'b0;
    if (wr_go && bus_clk_unmasked)
    begin
      case (aw_addr)
        `PRS_OFS_CTRL:
        begin
          if (ctrl_busy)
            wr_err = 1'b1;
          else if (w_strb[0])
          begin
            start[`PRS_SYNC_SOFT_RESET_BIT]  = wr_ctrl[`PRS_CTRL_SOFT_RESET_BIT];
            start[`PRS_SYNC_ENABLE] = 1'b1;
          end
        end
        `PRS_OFS_COMPARE:
        begin
          if (busy[`PRS_SYNC_COMPARE])
            wr_err = 1'b1;
          else if (w_strb[1:0] != 2'b00)
            start[`PRS_SYNC_COMPARE] = 1'b1;
        end
        `PRS_OFS_CLKCFG:  wr_bad = 1'b0;
        `PRS_OFS_SCRATCH: wr_bad = 1'b0;
        default:          wr_bad = 1'b1;
      endcase
    end
    start[`PRS_SYNC_COUNT] = count_dirty && !busy[`PRS_SYNC_COUNT];
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= `PRS_ZERO32;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `PRS_RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= `PRS_RESP_OKAY;
      rdata   <= `PRS_ZERO32;
    end
    else
    begin
      if (awvalid && !aw_full)
      begin
        aw_full <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && !w_full)
      begin
        w_full <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_go)
      begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (wr_err || wr_bad) ? `PRS_RESP_SLVERR : `PRS_RESP_OKAY;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
      if (rd_go)
      begin
        rvalid <= 1'b1;
        rdata  <= bus_clk_unmasked ? rd_word : `PRS_ZERO32;
        rresp  <= (rd_bad && bus_clk_unmasked) ? `PRS_RESP_SLVERR : `PRS_RESP_OKAY;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////
  // One synchroniser per channel (soft reset, enable, compare, count): six generic clock pulses out, then bus cycles back.

  integer i;
  integer j;
  always @*
  begin
    for (i = 0; i < `PRS_SYNC_NUM; i = i + 1)
    begin
      apply[i] = busy[i] && generic_clock_unit_en && (scnt[i] == `PRS_SYNC_GENERIC_CLOCK_UNIT - 3'd1);
      done[i]  = busy[i] && (scnt[i] == `PRS_SYNC_GENERIC_CLOCK_UNIT) && (sret[i] == `PRS_SYNC_RET);
    end
  end

  always @(posedge aclk)
  begin
    for (j = 0; j < `PRS_SYNC_NUM; j = j + 1)
    begin
      if (!aresetn)
      begin
        busy[j] <= 1'b0;
        scnt[j] <= 3'd0;
        sret[j] <= 2'd0;
      end
      else if (start[j])
      begin
        busy[j] <= 1'b1;
        scnt[j] <= 3'd0;
        sret[j] <= 2'd0;
      end
      else if (done[j])
        busy[j] <= 1'b0;
      else if (busy[j] && scnt[j] != `PRS_SYNC_GENERIC_CLOCK_UNIT)
      begin
        if (generic_clock_unit_en)
          scnt[j] <= scnt[j] + 3'd1;
      end
      else if (busy[j])
        sret[j] <= sret[j] + 2'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////
  // Core domain: enable, compare and a counter that clears on a compare match, all stepped by generic_clock_unit_en.

  reg                core_enable;
  reg  [15:0]        core_compare;
  reg  [COUNT_W-1:0] core_count;
  reg  [COUNT_W-1:0] count_snap;
  wire               core_reset = apply[`PRS_SYNC_SOFT_RESET_BIT];

  always @(posedge aclk)
  begin
    if (!aresetn || core_reset)
    begin
      core_enable  <= 1'b0;
      core_compare <= 16'h0000;
      core_count   <= {COUNT_W{1'b0}};
      count_snap   <= {COUNT_W{1'b0}};
    end
    else
    begin
      if (apply[`PRS_SYNC_ENABLE])
        core_enable <= ctl_enable;
      if (apply[`PRS_SYNC_COMPARE])
        core_compare <= compare_bus;
      if (apply[`PRS_SYNC_COUNT])
        count_snap <= core_count;
      if (generic_clock_unit_en && core_enable && clock_available)
      begin
        if (core_compare != 16'h0000 && core_count[15:0] == core_compare)
          core_count <= {COUNT_W{1'b0}};
        else
          core_count <= core_count + {{(COUNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  wire count_change = generic_clock_unit_en && core_enable && clock_available;

  //////////////////////////////////////////////////////////////////////////////////////////////////////
  // Bus-side register updates.

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_soft_reset_bit     <= 1'b0;
      ctl_enable    <= 1'b0;
      ctl_keeprun   <= 1'b0;
      compare_bus   <= 16'h0000;
      count_bus     <= {COUNT_W{1'b0}};
      clkcfg        <= `PRS_CFG_RESET;
      scratch       <= `PRS_ZERO32;
      pend_count    <= 1'b0;
      wake_launched <= 1'b0;
      count_dirty   <= 1'b0;
    end
    else if (done[`PRS_SYNC_SOFT_RESET_BIT])
    begin
      ctl_soft_reset_bit     <= 1'b0;
      ctl_enable    <= 1'b0;
      ctl_keeprun   <= 1'b0;
      compare_bus   <= 16'h0000;
      count_bus     <= {COUNT_W{1'b0}};
      scratch       <= `PRS_ZERO32;
      pend_count    <= wake_pulse;
      wake_launched <= 1'b0;
      count_dirty   <= wake_pulse;
    end
    else
    begin
      if (start[`PRS_SYNC_SOFT_RESET_BIT])
        ctl_soft_reset_bit <= 1'b1;
      if (start[`PRS_SYNC_ENABLE])
      begin
        ctl_enable  <= wr_ctrl[`PRS_CTRL_ENABLE];
        ctl_keeprun <= wr_ctrl[`PRS_CTRL_KEEPRUN];
      end
      if (start[`PRS_SYNC_COMPARE])
        compare_bus <= wr_cmp[15:0];
      if (wr_go && bus_clk_unmasked && aw_addr == `PRS_OFS_CLKCFG)
        clkcfg <= merge(clkcfg, w_data, w_strb) & {29'h0, 3'h7};
      if (wr_go && bus_clk_unmasked && aw_addr == `PRS_OFS_SCRATCH)
        scratch <= merge(scratch, w_data, w_strb);
      // A change or wake in the launch cycle re-arms the flag, so no update is lost.
      if (count_change || wake_pulse)
        count_dirty <= 1'b1;
      else if (start[`PRS_SYNC_COUNT])
        count_dirty <= 1'b0;
      if (start[`PRS_SYNC_COUNT])
        wake_launched <= pend_count;
      if (done[`PRS_SYNC_COUNT])
        count_bus <= count_snap;
      if (wake_pulse)
        pend_count <= 1'b1;
      else if (done[`PRS_SYNC_COUNT] && wake_launched)
        pend_count <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////
  // On-request clock path from the peripheral through the generic clock unit to the source.

  reg  [2:0]  src_state;
  reg  [15:0] src_cnt;
  wire        periph_req = core_enable && (!standby || ctl_keeprun);
  wire        src_req    = periph_req && clkcfg[`PRS_CFG_GEN_EN] && clkcfg[`PRS_CFG_CHAN_EN];
  wire        src_on     = src_req || !clkcfg[`PRS_CFG_ONREQ];

  assign clock_request   = src_req;
  assign source_running  = (src_state != SRC_OFF);
  assign clock_available = (src_state == SRC_RUN) || (src_state == SRC_HALT) || (src_state == SRC_LAST);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      src_state <= SRC_OFF;
      src_cnt   <= 16'h0000;
    end
    else
    begin
      case (src_state)
        SRC_OFF:
        begin
          src_cnt <= 16'h0000;
          if (src_on)
            src_state <= SRC_START;
        end
        SRC_START:
        begin
          src_cnt <= src_cnt + 16'h0001;
          if (src_cnt == STARTUP_CYC[15:0])
            src_state <= SRC_ALIGN;
        end
        SRC_ALIGN:
        begin
          if (generic_clock_unit_en)
            src_state <= SRC_RUN;
        end
        SRC_RUN:
        begin
          if (!src_on)
            src_state <= SRC_HALT;
        end
        SRC_HALT:
        begin
          if (src_on)
            src_state <= SRC_RUN;
          else if (generic_clock_unit_en)
            src_state <= SRC_LAST;
        end
        SRC_LAST:
        begin
          src_state <= src_on ? SRC_RUN : SRC_OFF;
        end
        default:
          src_state <= SRC_OFF;
      endcase
    end
  end

endmodule

/* bench/prs_axi_master.sv */
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module prs_axi_master (
  input  wire        aclk,
  output reg  [7:0]  awaddr,
  output reg         awvalid,
  input  wire        awready,
  output reg  [31:0] wdata,
  output reg  [3:0]  wstrb,
  output reg         wvalid,
  input  wire        wready,
  input  wire [1:0]  bresp,
  input  wire        bvalid,
  output reg         bready,
  output reg  [7:0]  araddr,
  output reg         arvalid,
  input  wire        arready,
  input  wire [31:0] rdata,
  input  wire [1:0]  rresp,
  input  wire        rvalid,
  output reg         rready
);
  // Response ready stays high, so the master never has to drop and raise it in one step.
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = 55'h0;
    {bready, rready} = 2'h3;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Offers address and data together and releases each when it is taken.
  task automatic wr_word(input [7:0] addr, input [31:0] data, input [3:0] strb, output [1:0] resp);
    reg done;
    begin
      done = 1'b0;
      awaddr <= addr;
      wdata <= data;
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!done)
      begin
        @(posedge aclk);
        if (awvalid && awready === 1'b1)
          awvalid <= 1'b0;
        if (wvalid && wready === 1'b1)
          wvalid <= 1'b0;
        if (bvalid === 1'b1)
        begin
          resp = bresp;
          done = 1'b1;
        end
      end
    end
  endtask

  task automatic rd_word(input [7:0] addr, output [31:0] data, output [1:0] resp);
    reg done;
    begin
      done = 1'b0;
      araddr <= addr;
      arvalid <= 1'b1;
      while (!done)
      begin
        @(posedge aclk);
        if (arvalid && arready === 1'b1)
          arvalid <= 1'b0;
        if (rvalid === 1'b1)
        begin
          data = rdata;
          resp = rresp;
          done = 1'b1;
        end
      end
    end
  endtask
endmodule

/* bench/prs_sync_bridge_properties.sv */
`timescale 1ns/1ps
`include "prs_map.vh"

//////////////////////////////////////////////////////////////////////////////
module prs_sync_bridge_properties #(
  parameter GENERIC_CLOCK_UNIT_DIV   = 4,
  parameter STARTUP_NS = 100
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready,
  input wire        bus_clk_unmasked,
  input wire        clock_request,
  input wire        source_running,
  input wire        clock_available
);
  // Start window after eight quiet cycles: startup plus two source and two divided periods.
  localparam int START_LO = STARTUP_NS / 4 - 8;
  localparam int START_HI = STARTUP_NS / 4 + 2 + 2 * GENERIC_CLOCK_UNIT_DIV - 7;
  localparam int STOP_HI  = 2 * GENERIC_CLOCK_UNIT_DIV + 2;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_write_answer:
    assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("write answer late");
  chk_read_answer:
    assert property (arvalid && arready |=> rvalid) else $error("read answer late");
  chk_bresp_release:
    assert property (bvalid && bready |=> !bvalid) else $error("write answer held too long");
  chk_rdata_release:
    assert property (rvalid && rready |=> !rvalid) else $error("read answer held too long");
  chk_masked_read:
    assert property (arvalid && arready && !bus_clk_unmasked |=> rdata == `PRS_ZERO32)
      else $error("masked read gave data");
  chk_avail_running:
    assert property (clock_available |-> source_running) else $error("clock available while stopped");
  chk_start_delay:
    assert property ($rose(clock_request) && !source_running
      |-> !clock_available [*8] ##[START_LO:START_HI] clock_available) else $error("start delay wrong");
  chk_stop_delay:
    assert property ($fell(clock_request) && clock_available |-> ##[1:STOP_HI] !source_running)
      else $error("stop delay wrong");
endmodule

bind prs_sync_bridge prs_sync_bridge_properties #(.GENERIC_CLOCK_UNIT_DIV(GENERIC_CLOCK_UNIT_DIV), .STARTUP_NS(STARTUP_NS))
  prs_sync_bridge_properties_i (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rvalid, .rready, .bus_clk_unmasked, .clock_request, .source_running,
  .clock_available);

/* bench/prs_sync_bridge_tb_top.sv */
`timescale 1ns/1ps
`include "prs_map.vh"

//////////////////////////////////////////////////////////////////////////////
module prs_sync_bridge_tb_top;
  localparam int   DIV = 4;
  localparam [1:0] OK  = `PRS_RESP_OKAY;
  localparam [1:0] ERR = `PRS_RESP_SLVERR;
  reg              aclk;
  reg              aresetn;
  reg              bus_clk_unmasked;
  reg              standby;
  reg              wake_pulse;
  wire [7:0]       awaddr, araddr;
  wire [31:0]      wdata, rdata;
  wire [3:0]       wstrb;
  wire [1:0]       bresp, rresp;
  wire             awvalid, awready, wvalid, wready, bvalid, bready;
  wire             arvalid, arready, rvalid, rready;
  wire             clock_request, source_running, clock_available;
  integer          bad_count, tests_run, cycle, t0, n;
  reg  [31:0]      cnt_seen;
  reg  [1:0]       cnt_resp;

  prs_sync_bridge #(.GENERIC_CLOCK_UNIT_DIV(DIV), .STARTUP_NS(`PRS_STARTUP_NS), .COUNT_W(16)) prs_sync_bridge_i (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .bus_clk_unmasked,
    .standby, .wake_pulse, .clock_request, .source_running, .clock_available);
  prs_axi_master prs_axi_master_i (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  initial
  begin
    aclk = 1'b0;
    forever
      #2 aclk = ~aclk;
  end

  always @(posedge aclk)
    cycle <= cycle + 1;

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task automatic pin(input got, input exp);
    check({31'h0, got}, {31'h0, exp});
  endtask

  task automatic rd_check(input [7:0] addr, input [31:0] exp, input [1:0] exp_resp);
    reg [31:0] d;
    reg [1:0]  r;
    begin
      prs_axi_master_i.rd_word(addr, d, r);
      check(d, exp);
      check({30'h0, r}, {30'h0, exp_resp});
    end
  endtask

  task automatic wr_check(input [7:0] addr, input [31:0] data, input [3:0] strb, input [1:0] exp_resp);
    reg [1:0] r;
    begin
      prs_axi_master_i.wr_word(addr, data, strb, r);
      check({30'h0, r}, {30'h0, exp_resp});
    end
  endtask

  // Polls the pending register until the masked bits clear; n is the time since t0.
  task automatic poll(input [31:0] mask);
    reg [31:0] d;
    reg [1:0]  r;
    integer    k;
    begin
      k = 0;
      d = mask;
      while ((d & mask) != 32'h0 && k < 80)
      begin
        prs_axi_master_i.rd_word(`PRS_OFS_PENDING, d, r);
        k = k + 1;
      end
      n = cycle - t0;
      check(d & mask, 32'h0);
    end
  endtask

  task automatic tick(input integer c);
    repeat (c) @(posedge aclk);
  endtask

  task final_report;
    begin
      $display("checks made %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  initial
  begin
    tick(20000);
    bad_count = bad_count + 1;
    final_report;
  end

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, standby, wake_pulse, bus_clk_unmasked} = 4'h1;
    {bad_count, tests_run, cycle, t0, n} = 160'h0;
    tick(20);
    aresetn <= 1'b1;
    tick(1);
    rd_check(`PRS_OFS_CLKCFG, `PRS_CFG_RESET, OK);
    rd_check(`PRS_OFS_PENDING, 32'h0, OK);
    rd_check(`PRS_OFS_STATUS, 32'h1, OK);
    rd_check(8'h1C, 32'h0, ERR);
    wr_check(8'h1C, 32'h1, 4'hF, ERR);
    $display("test reset_and_map finished");
    wr_check(`PRS_OFS_CTRL, 32'h2, 4'h1, OK);
    t0 = cycle;
    rd_check(`PRS_OFS_CTRL, 32'h2, OK);
    rd_check(`PRS_OFS_PENDING, 32'h2, OK);
    rd_check(`PRS_OFS_STATUS, 32'h0, OK);
    wr_check(`PRS_OFS_CTRL, 32'h2, 4'h1, ERR);
    wr_check(`PRS_OFS_COMPARE, 32'h1234, 4'h3, OK);
    wr_check(`PRS_OFS_COMPARE, 32'h4321, 4'h3, ERR);
    poll(32'h2);
    pin(n > 5 * DIV + 2 && n <= 6 * DIV + 6, 1'b1);
    poll(32'hF);
    rd_check(`PRS_OFS_STATUS, 32'h1, OK);
    $display("test enable_sync finished");
    wr_check(`PRS_OFS_CTRL, 32'h2, 4'h1, OK);
    rd_check(`PRS_OFS_PENDING, 32'h2, OK);
    poll(32'hF);
    wr_check(`PRS_OFS_SCRATCH, 32'h55, 4'hF, OK);
    wr_check(`PRS_OFS_CTRL, 32'h3, 4'h1, OK);
    rd_check(`PRS_OFS_CTRL, 32'h3, OK);
    rd_check(`PRS_OFS_PENDING, 32'h3, OK);
    wr_check(`PRS_OFS_CTRL, 32'h1, 4'h1, ERR);
    poll(32'hF);
    rd_check(`PRS_OFS_CTRL, 32'h0, OK);
    rd_check(`PRS_OFS_SCRATCH, 32'h0, OK);
    $display("test soft_reset finished");
    wr_check(`PRS_OFS_SCRATCH, 32'h77, 4'hF, OK);
    bus_clk_unmasked <= 1'b0;
    wr_check(`PRS_OFS_SCRATCH, 32'hA5, 4'hF, OK);
    rd_check(`PRS_OFS_SCRATCH, 32'h0, OK);
    bus_clk_unmasked <= 1'b1;
    rd_check(`PRS_OFS_SCRATCH, 32'h77, OK);
    $display("test masked_interface finished");
    wr_check(`PRS_OFS_CLKCFG, 32'h3, 4'hF, OK);
    tick(4);
    pin(source_running, 1'b1);
    pin(clock_request, 1'b0);
    wr_check(`PRS_OFS_CLKCFG, 32'h7, 4'hF, OK);
    tick(32);
    pin(source_running, 1'b0);
    wr_check(`PRS_OFS_CTRL, 32'h2, 4'h1, OK);
    poll(32'h2);
    pin(clock_request, 1'b1);
    tick(40);
    pin(clock_available, 1'b1);
    wr_check(`PRS_OFS_CLKCFG, 32'h5, 4'hF, OK);
    pin(clock_request, 1'b0);
    tick(12);
    pin(source_running, 1'b0);
    wr_check(`PRS_OFS_CLKCFG, 32'h6, 4'hF, OK);
    pin(clock_request, 1'b0);
    wr_check(`PRS_OFS_CLKCFG, 32'h7, 4'hF, OK);
    tick(40);
    pin(clock_available, 1'b1);
    $display("test clock_request finished");
    standby <= 1'b1;
    tick(2);
    pin(clock_request, 1'b0);
    tick(12);
    standby <= 1'b0;
    tick(40);
    wr_check(`PRS_OFS_CTRL, 32'h42, 4'h1, OK);
    poll(32'h2);
    standby <= 1'b1;
    tick(2);
    pin(clock_request, 1'b1);
    standby <= 1'b0;
    $display("test standby finished");
    rd_check(`PRS_OFS_PENDING, 32'h0, OK);
    wr_check(`PRS_OFS_CTRL, 32'h0, 4'h1, OK);
    poll(32'h2);
    tick(60);
    prs_axi_master_i.rd_word(`PRS_OFS_COUNT, cnt_seen, cnt_resp);
    pin(cnt_seen != 32'h0 && cnt_resp == OK, 1'b1);
    wake_pulse <= 1'b1;
    tick(1);
    wake_pulse <= 1'b0;
    rd_check(`PRS_OFS_PENDING, 32'h8, OK);
    rd_check(`PRS_OFS_COUNT, cnt_seen, OK);
    poll(32'h8);
    rd_check(`PRS_OFS_COUNT, cnt_seen, OK);
    rd_check(`PRS_OFS_COUNT, cnt_seen, OK);
    tick(40);
    rd_check(`PRS_OFS_PENDING, 32'h0, OK);
    $display("test wake finished");
    final_report;
  end
endmodule
